// *** crc_slot_acc.sv ***
// CRC-32 accumulator, one 64-bit slot word per cycle, MSB first
// Assumes start and step never meet in one cycle
module crc_slot_acc
    import dcap_frame_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    crc_step_if.slave        cs
);
    typedef struct packed {
        logic [CRC_W-1:0] rem;
        logic             first;
    } acc_state_type;

    acc_state_type st_ff;
    acc_state_type nxt_st;

    // Bitwise division of one slot word
    function automatic logic [CRC_W-1:0] crc_word(input logic [CRC_W-1:0] r,
                                                  input logic [SLOT_W-1:0] d);
        logic [CRC_W-1:0] c;
        logic             fb;
        c = r;
        for (int i = SLOT_W - 1; i >= 0; i--) begin
            fb = c[CRC_W-1] ^ d[i];
            c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
        end
        return c;
    endfunction

    // Complement of the first word's top half, zero start
    always_comb begin
        logic [SLOT_W-1:0] w;
        w      = cs.word;
        nxt_st = st_ff;
        if (cs.start) begin
            nxt_st.rem   = '0;
            nxt_st.first = 1'b1;
        end else if (cs.step) begin
            if (st_ff.first) begin
                w[SLOT_W-1 -: CRC_W] = ~cs.word[SLOT_W-1 -: CRC_W];
            end
            nxt_st.rem   = crc_word(st_ff.rem, w);
            nxt_st.first = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{rem: '0, first: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Final remainder inverted
    assign cs.crc = ~st_ff.rem;
endmodule

// *** crc_step_if.sv ***
// Interface joining the framer to its CRC accumulator
// Assumes both ends on mclk
interface crc_step_if;
    import dcap_frame_pkg::*;
    logic              start;
    logic              step;
    logic [SLOT_W-1:0] word;
    logic [CRC_W-1:0]  crc;

    modport master (output start, output step, output word, input crc);
    modport slave  (input start, input step, input word, output crc);
endinterface

// *** dcap1_packet_framer.sv ***
// Packet framer: builds header, padded data and trailer slot words
// Assumes a client that holds request fields stable while reqValid is high
module dcap1_packet_framer
    import dcap_frame_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    // Adaptation client interface: request
    input  wire logic                  reqValid,
    input  wire logic [7:0]            channelMuxIdentifier,
    input  wire logic [1:0]            packetPriorityField,
    input  wire logic [LEN_W-1:0]      reqLength,
    input  wire logic                  reqTrailer,
    input  wire logic                  reqCrcEnable,
    output logic                       reqReady,
    // Adaptation client interface: payload words
    input  wire logic                  dataValid,
    input  wire logic [SLOT_W-1:0]     dataWord,
    output logic                       dataReady,
    // Channel slot stream
    output logic                       slotValid,
    output logic [SLOT_W-1:0]          slotWord,
    output logic                       slotLast,
    // Register port
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [REG_DATA_W-1:0] regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic [REG_DATA_W-1:0]      regRdata
);

    //**********************************************************
    // State
    //**********************************************************
    typedef struct packed {
        frame_state_type   fsm;
        logic [7:0]        mux;
        logic [1:0]        packet_priority_field;
        logic [LEN_W-1:0]  len;
        logic              trl;
        logic              cen;
        logic [13:0]       wordsLeft;
        logic              reqReady;
        logic              dataReady;
        logic              slotValid;
        logic [SLOT_W-1:0] slotWord;
        logic              slotLast;
        logic              enable;
        logic [15:0]       frames;
        logic [REG_DATA_W-1:0] rdata;
    } framer_state_type;

    framer_state_type st_ff;
    framer_state_type nxt_st;

    // Clock and reset for the assertions at the end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    crc_step_if crcLink ();

    crc_slot_acc u_crc (
        .mclk   (mclk),
        .resetn (resetn),
        .cs     (crcLink.slave)
    );

    //**********************************************************
    // Helper functions
    //**********************************************************
    // Number of data words from a byte length, rounded up
    function automatic logic [13:0] word_count(input logic [LEN_W-1:0] l);
        return 14'(l >> BYTE_SHIFT) + 14'((l[2:0] & BYTE_MASK) != 3'h0);
    endfunction

    // Zero the pad bytes of a last data word
    function automatic logic [SLOT_W-1:0] pad_word(input logic [SLOT_W-1:0] w,
                                                   input logic [LEN_W-1:0]  l);
        logic [SLOT_W-1:0] o;
        o = w;
        if (l[2:0] != 3'h0) begin
            for (int b = 0; b < SLOT_W / 8; b++) begin
                if (b < (SLOT_W / 8) - int'(l[2:0])) begin
                    o[b*8 +: 8] = 8'h00;
                end
            end
        end
        return o;
    endfunction

    // Header slot word with checksum
    function automatic logic [SLOT_W-1:0] build_header(input logic [7:0] m,
                                                       input logic [1:0] p,
                                                       input logic [LEN_W-1:0] l,
                                                       input logic t,
                                                       input logic c);
        logic [SLOT_W-1:0] h;
        h = '0;
        h[HDR_VER_LSB +: 4]     = VERSION_ONE;
        h[HDR_MUX_LSB +: 8]     = m;
        h[HDR_LEN_LSB +: LEN_W] = l;
        h[HDR_PAT_LSB +: 8]     = HDR_PATTERN;
        h[HDR_CEN_BIT]          = c;
        h[HDR_TRL_BIT]          = t;
        h[HDR_PRI_LSB +: 2]     = p;
        h[7:0]                  = slot_checksum(h);
        return h;
    endfunction

    // Trailer slot word with checksum
    function automatic logic [SLOT_W-1:0] build_trailer(input logic [CRC_W-1:0] crc,
                                                        input logic c);
        logic [SLOT_W-1:0] t;
        t = '0;
        t[TRL_CRC_LSB +: CRC_W] = c ? crc : '0;
        t[TRL_PAT_LSB +: 8]     = TRL_PATTERN;
        t[TRL_VAL_BIT]          = c;
        t[7:0]                  = slot_checksum(t);
        return t;
    endfunction

    //**********************************************************
    // CRC accumulator drive
    //**********************************************************
    assign crcLink.start = (st_ff.fsm == ST_HEADER);
    assign crcLink.step  = (st_ff.fsm == ST_DATA) && dataValid && st_ff.dataReady;
    assign crcLink.word  = pad_word(dataWord, st_ff.wordsLeft == 14'h1 ? st_ff.len : '0);

    //**********************************************************
    // Next-state logic
    //**********************************************************
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.slotValid = 1'b0;
        nxt_st.slotLast  = 1'b0;
        nxt_st.rdata     = '0;
        case (st_ff.fsm)
            ST_IDLE: begin
                // Capture a request when enabled
                nxt_st.reqReady = st_ff.enable;
                if (reqValid && st_ff.reqReady && reqLength != '0) begin
                    nxt_st.mux      = channelMuxIdentifier;
                    nxt_st.packet_priority_field      = packetPriorityField;
                    nxt_st.len      = reqLength;
                    nxt_st.trl      = reqTrailer;
                    nxt_st.cen      = reqCrcEnable & reqTrailer;
                    nxt_st.reqReady = 1'b0;
                    nxt_st.fsm      = ST_HEADER;
                end
            end
            ST_HEADER: begin
                // Header leads the frame, data follows at once
                nxt_st.slotValid = 1'b1;
                nxt_st.slotWord  = build_header(st_ff.mux, st_ff.packet_priority_field, st_ff.len,
                                                st_ff.trl, st_ff.cen);
                nxt_st.wordsLeft = word_count(st_ff.len);
                nxt_st.dataReady = 1'b1;
                nxt_st.fsm       = ST_DATA;
            end
            ST_DATA: begin
                // Forward each payload word, padding the last
                if (dataValid && st_ff.dataReady) begin
                    nxt_st.slotValid = 1'b1;
                    nxt_st.slotWord  = crcLink.word;
                    nxt_st.wordsLeft = st_ff.wordsLeft - 14'h1;
                    if (st_ff.wordsLeft == 14'h1) begin
                        nxt_st.dataReady = 1'b0;
                        if (st_ff.trl) begin
                            nxt_st.fsm = ST_TRAILER;
                        end else begin
                            nxt_st.slotLast = 1'b1;
                            nxt_st.frames   = st_ff.frames + 16'h1;
                            nxt_st.fsm      = ST_IDLE;
                        end
                    end
                end
            end
            ST_TRAILER: begin
                // CRC is complete one cycle after the last word
                nxt_st.slotValid = 1'b1;
                nxt_st.slotWord  = build_trailer(crcLink.crc, st_ff.cen);
                nxt_st.slotLast  = 1'b1;
                nxt_st.frames    = st_ff.frames + 16'h1;
                nxt_st.fsm       = ST_IDLE;
            end
            default: begin
                nxt_st.fsm = ST_IDLE;
            end
        endcase

        // Register writes
        if (regWrite && regAddr == REG_CTRL) begin
            nxt_st.enable = regWdata[CTRL_EN_BIT];
            if (regWdata[CTRL_CLR_BIT]) begin
                nxt_st.frames = '0;
            end
        end
        if (!nxt_st.enable) begin
            nxt_st.reqReady = 1'b0;
        end

        // Register reads, data in the following cycle
        if (regRead) begin
            case (regAddr)
                REG_CTRL:   nxt_st.rdata = {31'h0, st_ff.enable};
                REG_STATUS: nxt_st.rdata = {14'h0, st_ff.fsm, 2'h0, st_ff.wordsLeft};
                REG_COUNT:  nxt_st.rdata = {16'h0, st_ff.frames};
                default:    nxt_st.rdata = '0;
            endcase
        end
    end

    //**********************************************************
    // State register
    //**********************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff        <= '0;
            st_ff.fsm    <= ST_IDLE;
            st_ff.enable <= CTRL_RESET[CTRL_EN_BIT];
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reqReady  = st_ff.reqReady;
    assign dataReady = st_ff.dataReady;
    assign slotValid = st_ff.slotValid;
    assign slotWord  = st_ff.slotWord;
    assign slotLast  = st_ff.slotLast;
    assign regRdata  = st_ff.rdata;

    //**********************************************************
    // Assertions
    //**********************************************************
    AST_HDR_THEN_DATA: assert property (@(posedge mclk) disable iff (!resetn)
        st_ff.fsm == ST_HEADER |=> slotValid && slotWord[HDR_PAT_LSB +: 8] == HDR_PATTERN
            && st_ff.fsm == ST_DATA)
        else $error("header not followed by data phase");
    AST_VERSION: assert property (@(posedge mclk) disable iff (!resetn)
        $past(st_ff.fsm) == ST_HEADER |-> slotWord[63:60] == VERSION_ONE)
        else $error("bad version in header");
    AST_HDR_SUM: assert property (@(posedge mclk) disable iff (!resetn)
        slotValid && $past(st_ff.fsm) != ST_DATA |-> slotWord[7:0] == slot_checksum(slotWord))
        else $error("slot checksum wrong");
    AST_HDR_RESERVED: assert property (@(posedge mclk) disable iff (!resetn)
        $past(st_ff.fsm) == ST_HEADER |-> slotWord[59:56] == 4'h0
            && slotWord[31:24] == 8'h0 && slotWord[14] == 1'b0 && slotWord[10:8] == 3'h0)
        else $error("header reserved bits set");
    AST_TRL_FIELDS: assert property (@(posedge mclk) disable iff (!resetn)
        $past(st_ff.fsm) == ST_TRAILER |-> slotLast && slotWord[TRL_PAT_LSB +: 8]
            == TRL_PATTERN && slotWord[14:8] == 7'h0 && slotWord[31:24] == 8'h0)
        else $error("trailer fields wrong");
    AST_TRL_FLAG: assert property (@(posedge mclk) disable iff (!resetn)
        st_ff.fsm == ST_DATA && crcLink.step && st_ff.wordsLeft == 14'h1 |=>
            (st_ff.fsm == ST_TRAILER) == st_ff.trl)
        else $error("trailer presence disagrees with flag");
    AST_WORD_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
        st_ff.fsm == ST_HEADER |=>
            st_ff.wordsLeft == 14'((17'(st_ff.len) + 17'(BYTE_MASK)) >> BYTE_SHIFT))
        else $error("data word count wrong");
    AST_PAD_LOW: assert property (@(posedge mclk) disable iff (!resetn)
        crcLink.step && st_ff.wordsLeft == 14'h1 && st_ff.len[2:0] != 3'h0 |=>
            slotWord[7:0] == 8'h00)
        else $error("pad byte not zero");

    // Field and handshake guards on the default clock

    AST_HDR_MUX: assert property (
        $past(st_ff.fsm) == ST_HEADER |-> slotWord[HDR_MUX_LSB +: 8] == st_ff.mux)
        else $error("header mux id wrong");

    AST_HDR_LEN: assert property (
        $past(st_ff.fsm) == ST_HEADER |-> slotWord[HDR_LEN_LSB +: LEN_W] == st_ff.len)
        else $error("header length wrong");

    AST_HDR_FLAGS: assert property (
        $past(st_ff.fsm) == ST_HEADER |-> slotWord[HDR_CEN_BIT] == st_ff.cen
            && slotWord[HDR_TRL_BIT] == st_ff.trl)
        else $error("header flags wrong");

    AST_HDR_PRI: assert property (
        $past(st_ff.fsm) == ST_HEADER |-> slotWord[HDR_PRI_LSB +: 2] == st_ff.packet_priority_field)
        else $error("header priority wrong");

    AST_TRL_VALID: assert property (
        $past(st_ff.fsm) == ST_TRAILER |-> slotWord[TRL_VAL_BIT] == st_ff.cen)
        else $error("trailer valid flag wrong");

    AST_TRL_NO_CRC: assert property (
        $past(st_ff.fsm) == ST_TRAILER && !st_ff.cen |-> slotWord[63:32] == '0)
        else $error("unused trailer CRC not zero");

    AST_LAST_VALID: assert property (
        slotLast |-> slotValid)
        else $error("last flag without slot word");

    AST_LAST_PULSE: assert property (
        slotLast |=> !slotLast)
        else $error("last flag held");

    AST_READY_IDLE: assert property (
        reqReady |-> st_ff.fsm == ST_IDLE && st_ff.enable)
        else $error("request ready outside idle");

    AST_DATA_READY: assert property (
        dataReady |-> st_ff.fsm == ST_DATA && st_ff.wordsLeft != '0)
        else $error("data ready outside data phase");

    AST_LEN_NONZERO: assert property (
        st_ff.fsm == ST_HEADER |-> st_ff.len != '0)
        else $error("empty request taken");

    AST_DATA_AT_ONCE: assert property (
        $past(st_ff.fsm) == ST_HEADER |-> dataReady)
        else $error("data phase not open after header");

    AST_CEN_TRAILER: assert property (
        st_ff.cen |-> st_ff.trl)
        else $error("CRC enable without trailer");

    AST_WORDS_LEFT: assert property (
        st_ff.fsm == ST_DATA |-> st_ff.wordsLeft != '0)
        else $error("data phase with no words left");
endmodule

// *** dcap_frame_pkg.sv ***
// Constants and types shared by the packet framer files
// Assumes a single 250 MHz clock domain
package dcap_frame_pkg;

    localparam int unsigned SLOT_W       = 64;
    localparam int unsigned CRC_W        = 32;
    localparam int unsigned LEN_W        = 16;
    localparam int unsigned REG_ADDR_W   = 4;
    localparam int unsigned REG_DATA_W   = 32;

    // Header field positions
    localparam int unsigned HDR_VER_LSB  = 60;
    localparam int unsigned HDR_MUX_LSB  = 48;
    localparam int unsigned HDR_LEN_LSB  = 32;
    localparam int unsigned HDR_PAT_LSB  = 16;
    localparam int unsigned HDR_CEN_BIT  = 15;
    localparam int unsigned HDR_TRL_BIT  = 13;
    localparam int unsigned HDR_PRI_LSB  = 11;
    // Trailer field positions
    localparam int unsigned TRL_CRC_LSB  = 32;
    localparam int unsigned TRL_PAT_LSB  = 16;
    localparam int unsigned TRL_VAL_BIT  = 15;

    localparam logic [3:0]  VERSION_ONE  = 4'h0;
    localparam logic [7:0]  HDR_PATTERN  = 8'hAA;
    localparam logic [7:0]  TRL_PATTERN  = 8'h55;
    localparam logic [31:0] CRC_POLY     = 32'h04C1_1DB7;
    localparam logic [31:0] CRC_ONES     = 32'hFFFF_FFFF;
    localparam logic [2:0]  BYTE_SHIFT   = 3'h3;
    localparam logic [2:0]  BYTE_MASK    = 3'h7;

    // Register map (word addresses on the plain port)
    localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [REG_ADDR_W-1:0] REG_COUNT  = 4'h2;
    localparam logic [REG_DATA_W-1:0] CTRL_RESET = 32'h0000_0001;
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_CLR_BIT = 1;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_HEADER  = 2'b01,
        ST_DATA    = 2'b11,
        ST_TRAILER = 2'b10
    } frame_state_type;

    // Checksum: XOR of the seven octets above the checksum octet
    function automatic logic [7:0] slot_checksum(input logic [SLOT_W-1:0] w);
        logic [7:0] acc;
        acc = 8'h00;
        for (int i = 1; i < SLOT_W / 8; i++) begin
            acc = acc ^ w[i*8 +: 8];
        end
        return acc;
    endfunction

endpackage

// *** dcap_rx_model.sv ***
// Far-end packet receiver model watching the channel slot stream
// Assumes the framer's mclk domain and one slot word per slotValid pulse
module dcap_rx_model
    import dcap_frame_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              slotValid,
    input  wire logic [SLOT_W-1:0] slotWord,
    input  wire logic              slotLast,
    output logic [7:0]             errCount,
    output logic [7:0]             frameCount,
    output logic [1:0]             rxPriority
);
    logic        inFrame;
    logic        trlDue;
    logic [13:0] wordsLeft;

    // Octet parity of the seven upper octets
    function automatic logic [7:0] sum7(input logic [63:0] w);
        logic [7:0] a;
        a = 8'h00;
        for (int i = 1; i < 8; i++) a = a ^ w[i*8 +: 8];
        return a;
    endfunction

    // Header hunt, data count and trailer check; any slip bumps errCount
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            inFrame    <= 1'b0;
            trlDue     <= 1'b0;
            wordsLeft  <= 14'h0000;
            errCount   <= 8'h00;
            frameCount <= 8'h00;
            rxPriority <= 2'h0;
        end else if (slotValid) begin
            if (!inFrame) begin
                if (slotWord[63:60] != VERSION_ONE || slotWord[23:16] != HDR_PATTERN
                    || sum7(slotWord) != slotWord[7:0] || slotLast) begin
                    errCount <= errCount + 8'h01;
                end
                inFrame    <= 1'b1;
                wordsLeft  <= 14'((17'(slotWord[47:32]) + 17'h0_0007) >> 3);
                trlDue     <= slotWord[13];
                rxPriority <= slotWord[12:11];
            end else if (wordsLeft != 14'h0000) begin
                if (slotLast != (wordsLeft == 14'h0001 && !trlDue)) begin
                    errCount <= errCount + 8'h01;
                end
                wordsLeft <= wordsLeft - 14'h0001;
                if (slotLast) begin
                    inFrame    <= 1'b0;
                    frameCount <= frameCount + 8'h01;
                end
            end else begin
                if (slotWord[23:16] != TRL_PATTERN || sum7(slotWord) != slotWord[7:0]
                    || !slotLast) begin
                    errCount <= errCount + 8'h01;
                end
                inFrame    <= 1'b0;
                frameCount <= frameCount + 8'h01;
            end
        end
    end
endmodule

// *** test_dcap1_packet_framer.sv ***
// Self-checking bench for the packet framer with a far receiver model
// Assumes the framer's register map and request handshake as handed over
module test_dcap1_packet_framer
    import dcap_frame_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk, resetn, reqValid, reqTrailer, reqCrcEnable, reqReady;
    logic        dataValid, dataReady, slotValid, slotLast, regWrite, regRead;
    logic [7:0]  channelMuxIdentifier, rxErr, rxFrames;
    logic [1:0]  packetPriorityField, rxPri;
    logic [15:0] reqLength;
    logic [63:0] dataWord, slotWord;
    logic [3:0]  regAddr;
    logic [31:0] regWdata, regRdata, rd;
    logic [63:0] slots[$];
    int          lastIdx, nFrames, devFrames, cycles, n_errors, n_checks;

    dcap1_packet_framer uut (.mclk(mclk), .resetn(resetn), .reqValid(reqValid),
        .channelMuxIdentifier(channelMuxIdentifier), .packetPriorityField(packetPriorityField),
        .reqLength(reqLength), .reqTrailer(reqTrailer), .reqCrcEnable(reqCrcEnable),
        .reqReady(reqReady), .dataValid(dataValid), .dataWord(dataWord),
        .dataReady(dataReady), .slotValid(slotValid), .slotWord(slotWord),
        .slotLast(slotLast), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    dcap_rx_model rx (.mclk(mclk), .resetn(resetn), .slotValid(slotValid),
        .slotWord(slotWord), .slotLast(slotLast), .errCount(rxErr),
        .frameCount(rxFrames), .rxPriority(rxPri));

    // ****************************************
    // Clock, slot capture and hang guard
    // ****************************************
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (slotValid === 1'b1) slots.push_back(slotWord);
        if (slotLast === 1'b1) lastIdx = slots.size();
        cycles = cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            results();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [63:0] pay(input int i);
        return 64'h1122_3344_5566_7788 + 64'(i) * 64'h0101_0101_0101_0101;
    endfunction
    function automatic logic [7:0] xsum(input logic [63:0] w);
        logic [7:0] a;
        a = 8'h00;
        for (int i = 1; i < 8; i++) a = a ^ w[i*8 +: 8];
        return a;
    endfunction
    // One slot word into a zero-seeded, MSB-first remainder
    function automatic logic [31:0] crcWord(input logic [31:0] c, input logic [63:0] w,
                                            input logic first);
        logic fb;
        if (first) w[63:32] = ~w[63:32];
        for (int b = 63; b >= 0; b--) begin
            fb = c[31] ^ w[b];
            c = {c[30:0], 1'b0};
            if (fb) c = c ^ CRC_POLY;
        end
        return c;
    endfunction
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic regRd(input logic [3:0] a, output logic [31:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdata;
        @(posedge mclk);
    endtask

    // Send one frame and judge every slot word that comes out
    task automatic frame(input int len, input logic [7:0] mux, input logic [1:0] packet_priority_field,
                         input logic trl, input logic cen);
        int nw, k;
        logic [63:0] w, e;
        logic [31:0] crc;
        nw = (len + 7) / 8;
        slots.delete();
        lastIdx = -1;
        reqValid <= 1'b1;
        reqLength <= 16'(len);
        channelMuxIdentifier <= mux;
        packetPriorityField <= packet_priority_field;
        reqTrailer <= trl;
        reqCrcEnable <= cen;
        for (k = 0; k < 100; k++) begin
            @(posedge mclk);
            if (reqReady === 1'b1) break;
        end
        reqValid <= 1'b0;
        for (int i = 0; i < nw; i++) begin
            dataValid <= 1'b1;
            dataWord <= pay(i);
            for (k = 0; k < 100; k++) begin
                @(posedge mclk);
                if (dataReady === 1'b1) break;
            end
        end
        dataValid <= 1'b0;
        for (k = 0; k < 100 && lastIdx < 0; k++) @(posedge mclk);
        @(posedge mclk); // Far model counts the frame at the last edge
        nFrames++;
        devFrames++;
        check("slot count", 64'(slots.size()), 64'(1 + nw + int'(trl)));
        check("last index", 64'(lastIdx), 64'(1 + nw + int'(trl)));
        e = {VERSION_ONE, 4'h0, mux, 16'(len), 8'h00, HDR_PATTERN,
             cen & trl, 1'b0, trl, packet_priority_field, 3'h0, 8'h00};
        e[7:0] = xsum(e);
        check("header", slots[0], e);
        crc = 32'h0000_0000;
        for (int i = 0; i < nw; i++) begin
            w = pay(i);
            if (i == nw - 1 && len % 8 != 0) w = w & ({64{1'b1}} << (64 - 8 * (len % 8)));
            check("data", slots[1 + i], w);
            crc = crcWord(crc, w, i == 0);
        end
        if (trl) begin
            e = {cen ? ~crc : 32'h0000_0000, 8'h00, TRL_PATTERN, cen, 7'h00, 8'h00};
            e[7:0] = xsum(e);
            check("trailer", slots[nw + 1], e);
        end
        check("rx priority", 64'(rxPri), 64'(packet_priority_field));
        check("rx frames", 64'(rxFrames), 64'(8'(nFrames)));
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic tstCrcFrame();
        frame(13, 8'hA5, 2'h2, 1'b1, 1'b1);
    endtask
    task automatic tstPlainFrame();
        frame(8, 8'hFF, 2'h3, 1'b0, 1'b0);
    endtask
    task automatic tstNoCrcFrame();
        frame(1, 8'h00, 2'h1, 1'b1, 1'b0);
    endtask
    task automatic tstMaxFrame();
        frame(65535, 8'h3C, 2'h0, 1'b1, 1'b1);
    endtask
    task automatic tstRegs();
        regRd(REG_CTRL, rd);
        check("ctrl reset", 64'(rd), 64'(CTRL_RESET));
        regRd(4'hF, rd);
        check("unmapped", 64'(rd), 64'h0000_0000_0000_0000);
        regRd(REG_STATUS, rd);
        check("status idle", 64'(rd), 64'h0000_0000_0000_0000);
        regRd(REG_COUNT, rd);
        check("count", 64'(rd), 64'(devFrames));
        regWr(REG_CTRL, 32'h0000_0003);
        devFrames = 0;
        regRd(REG_COUNT, rd);
        check("count cleared", 64'(rd), 64'(devFrames));
    endtask
    // Disabled framer and a zero length must both leave the channel silent
    task automatic tstRefuse();
        slots.delete();
        regWr(REG_CTRL, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        reqValid <= 1'b1;
        reqLength <= 16'h0008;
        repeat (12) @(posedge mclk);
        check("ready disabled", 64'(reqReady), 64'h0000_0000_0000_0000);
        reqLength <= 16'h0000;
        regWr(REG_CTRL, 32'h0000_0001);
        repeat (12) @(posedge mclk);
        reqValid <= 1'b0;
        repeat (4) @(posedge mclk);
        check("refused slots", 64'(slots.size()), 64'h0000_0000_0000_0000);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        {reqValid, reqTrailer, reqCrcEnable, dataValid, regWrite, regRead} = 6'h00;
        {channelMuxIdentifier, packetPriorityField, reqLength} = 26'h000_0000;
        {dataWord, regAddr, regWdata} = '0;
        {nFrames, devFrames, cycles, n_errors, n_checks} = '0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        tstCrcFrame();
        tstPlainFrame();
        tstNoCrcFrame();
        tstRegs();
        tstRefuse();
        tstMaxFrame();
        check("rx errors", 64'(rxErr), 64'h0000_0000_0000_0000);
        results();
    end
endmodule
